/* logic/flash_page_ecc_calculator.sv */
// Page parity calculator with AHB-Lite register slave
//
// What this block does
// - Config bit 0 selects block size; rest zero
// - Any restart write clears running parity
// - First result byte holds row bits 15..8
// - Second result byte holds row bits 7..0
// - First set row bits 17..16 in byte bits 1..0 in large mode, zero in small mode
// - First set column parity in byte bits 7..2
// - Second set column bits 7..2, bits 1..0 zero
`timescale 1ns/1ns
`include "ecc_calc_defs.svh"
module flash_page_ecc_calculator
  import ecc_calc_pkg::*;
(
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // AHB-Lite slave
  input  wire logic                    hsel,
  input  wire ecc_calc_pkg::bus_word_t haddr,
  input  wire ecc_calc_pkg::htrans_t   htrans,
  input  wire logic                    hwrite,
  input  wire ecc_calc_pkg::hsize_t    hsize,
  input  wire ecc_calc_pkg::bus_word_t hwdata,
  input  wire logic                    hready,
  output ecc_calc_pkg::bus_word_t      hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // Byte stream to be protected
  input  wire logic                    byte_valid,
  input  wire ecc_calc_pkg::data_byte_t byte_data,
  output logic                         byte_ready
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Geometry and configuration reset image
  localparam int         SMALL_W   = `SMALL_BLOCK_ADDR_W;
  localparam int         LARGE_W   = `LARGE_BLOCK_ADDR_W;
  localparam logic [7:0] CFG_RESET = `ECC_MODE_CONFIG_RESET;

  // Bus address phase decode
  logic        addr_phase;
  logic [15:0] addr_index;
  logic        addr_in_range;
  logic        addr_aligned;
  logic        addr_word_ok;
  logic        read_req;
  logic        write_req;

  // Write held over to its data phase
  logic        wr_pending;
  logic [15:0] wr_index;
  logic        next_wr_pending;
  logic [15:0] next_wr_index;
  logic        cfg_write;

  // Configuration and restart
  logic        block_size_select;
  logic        next_block_size_select;
  logic        restart;

  // Read path
  bus_word_t   next_hrdata;
  logic [7:0]  read_byte;
  logic [7:0]  cfg_byte;
  logic [7:0]  first_byte_row_high;
  logic [7:0]  first_byte_row_low;
  logic [7:0]  first_byte_col_top;
  logic [7:0]  second_byte_row_high;
  logic [7:0]  second_byte_row_low;
  logic [7:0]  second_byte_col;

  // Byte stream and steering
  logic        fold;
  byte_index_t byte_index;
  logic        in_second_half;
  logic        fold_first;
  logic        fold_second;

  // Result sets
  logic [LARGE_W-1:0]       first_addr;
  logic [2*LARGE_W-1:0]     first_row;
  logic [`COL_PARITY_W-1:0] first_col;
  logic [2*SMALL_W-1:0]     second_row;
  logic [`COL_PARITY_W-1:0] second_col;
  logic [1:0]               first_row_top;
  block_mode_t              mode;

  // ****************************************************************
  // Bus address phase
  // ****************************************************************

  // Valid transfer seen; only aligned words decode
  // Upper bits must be zero so no alias reaches a register
  assign addr_phase    = hsel & htrans[1] & hready;
  assign addr_index    = haddr[17:2];
  assign addr_in_range = (haddr[31:18] == 14'h0000);
  assign addr_aligned  = (haddr[1:0] == 2'h0);
  assign addr_word_ok  = addr_in_range & addr_aligned;

  // Read and write requests; hsize ignored, every register is a word
  assign read_req  = addr_phase & ~hwrite;
  assign write_req = addr_phase & hwrite & addr_word_ok;

  // Bus never stalls and always answers OKAY
  // Zero wait states, so a read is captured at its address edge
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Stream side never stalls either
  assign byte_ready = 1'b1;

  // ****************************************************************
  // Bus data phase
  // ****************************************************************

  // Write request held over to its data phase
  always_comb begin
    next_wr_pending = 1'b0;
    next_wr_index   = wr_index;
    if (write_req) begin
      next_wr_pending = 1'b1;
      next_wr_index   = addr_index;
    end
  end

  // Pending write register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_index   <= 16'h0000;
    end else begin
      wr_pending <= next_wr_pending;
      wr_index   <= next_wr_index;
    end
  end

  // ****************************************************************
  // Configuration and restart
  // ****************************************************************

  // Configuration write lands at the end of its data phase
  assign cfg_write = wr_pending & (wr_index == `IDX_ECC_MODE_CONFIG);

  // Only bit 0 is kept, other bits are not stored
  always_comb begin
    next_block_size_select = block_size_select;
    if (cfg_write) begin
      next_block_size_select = hwdata[`BLOCK_SIZE_SELECT_BIT];
    end
  end

  // Mode register; a change mid-block is not guarded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_size_select <= CFG_RESET[`BLOCK_SIZE_SELECT_BIT];
    end else begin
      block_size_select <= next_block_size_select;
    end
  end

  // Mode as the enum the steering decodes
  assign mode = block_mode_t'(block_size_select);

  // Any data value written to the action register restarts
  // Restart wins over a byte folded at that same edge
  // Both result sets and the position counter clear together
  assign restart = wr_pending & (wr_index == `IDX_ECC_RESTART_ACTION);

  // ****************************************************************
  // Byte routing to the two result sets
  // ****************************************************************
  // Every valid byte is taken at once
  assign fold = byte_valid;

  // Byte position since the last restart
  block_position_counter #(
    .INDEX_W (LARGE_W)
  ) u_position (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .clear      (restart),
    .fold       (fold),
    .byte_index (byte_index)
  );

  // Top position bit picks the half in small mode
  assign in_second_half = byte_index[LARGE_W-1];

  // Small mode splits at the half; large mode feeds set one only
  always_comb begin
    fold_first  = 1'b0;
    fold_second = 1'b0;
    first_addr  = byte_index;
    case (mode)
      MODE_ONE_LARGE: begin
        fold_first = fold;
        first_addr = byte_index;
      end
      MODE_TWO_SMALL: begin
        fold_first  = fold & ~in_second_half;
        fold_second = fold & in_second_half;
        first_addr  = {1'b0, byte_index[SMALL_W-1:0]};
      end
      default: begin
        fold_first  = 1'b0;
        fold_second = 1'b0;
      end
    endcase
  end

  // Set one: first half, or the whole large block
  parity_result_set #(
    .ADDR_W (LARGE_W)
  ) u_first_set (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .clear      (restart),
    .fold       (fold_first),
    .byte_addr  (first_addr),
    .data       (byte_data),
    .row_parity (first_row),
    .col_parity (first_col)
  );

  // Set two: second half in small mode only
  parity_result_set #(
    .ADDR_W (SMALL_W)
  ) u_second_set (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .clear      (restart),
    .fold       (fold_second),
    .byte_addr  (byte_index[SMALL_W-1:0]),
    .data       (byte_data),
    .row_parity (second_row),
    .col_parity (second_col)
  );

  // Top row bits only carry meaning for the large block
  // In small mode bit 16 still toggles inside the set, so mask it here
  assign first_row_top = (mode == MODE_ONE_LARGE) ? first_row[17:16] : 2'h0;

  // ****************************************************************
  // Register images
  // ****************************************************************

  // Each readable register as the byte software sees
  assign cfg_byte             = {7'h00, block_size_select};
  assign first_byte_row_high  = first_row[15:8];
  assign first_byte_row_low   = first_row[7:0];
  assign first_byte_col_top   = {first_col, first_row_top};
  assign second_byte_row_high = second_row[15:8];
  assign second_byte_row_low  = second_row[7:0];
  assign second_byte_col      = {second_col, 2'h0};

  // ****************************************************************
  // Read data
  // ****************************************************************

  // Result byte selection; unmapped and write-only read zero
  always_comb begin
    read_byte = 8'h00;
    if (addr_word_ok) begin
      // Decode only the registers of this block
      case (addr_index)
        `IDX_ECC_MODE_CONFIG:    read_byte = cfg_byte;
        `IDX_ECC_RESTART_ACTION: read_byte = 8'h00;
        `IDX_FIRST_ROW_HIGH:     read_byte = first_byte_row_high;
        `IDX_FIRST_ROW_LOW:      read_byte = first_byte_row_low;
        `IDX_FIRST_COL_ROW_TOP:  read_byte = first_byte_col_top;
        `IDX_SECOND_ROW_HIGH:    read_byte = second_byte_row_high;
        `IDX_SECOND_ROW_LOW:     read_byte = second_byte_row_low;
        `IDX_SECOND_COL:         read_byte = second_byte_col;
        default:                 read_byte = 8'h00;
      endcase
    end
  end

  // Read data captured at the address phase edge
  // Bytes folded during the data phase show on the next read
  always_comb begin
    next_hrdata = hrdata;
    if (read_req) begin
      next_hrdata = {24'h000000, read_byte};
    end
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

endmodule : flash_page_ecc_calculator

/* shared/ecc_calc_defs.svh */
// Register offsets, field positions, reset values and sizes of the parity calculator
`ifndef ECC_CALC_DEFS_SVH
`define ECC_CALC_DEFS_SVH

// ****************************************************************
// Register indexes (byte address is four times the index)
// ****************************************************************
`define IDX_ECC_MODE_CONFIG      16'he628
`define IDX_ECC_RESTART_ACTION   16'he629
`define IDX_FIRST_ROW_HIGH       16'he62a
`define IDX_FIRST_ROW_LOW        16'he62b
`define IDX_FIRST_COL_ROW_TOP    16'he62c
`define IDX_SECOND_ROW_HIGH      16'he62d
`define IDX_SECOND_ROW_LOW       16'he62e
`define IDX_SECOND_COL           16'he62f

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define BLOCK_SIZE_SELECT_BIT    0
`define ECC_MODE_CONFIG_RESET    8'h00
`define RESULT_RESET             8'h00

// ****************************************************************
// Block geometry
// ****************************************************************
`define SMALL_BLOCK_ADDR_W       8
`define LARGE_BLOCK_ADDR_W       9
`define COL_PARITY_W             6

`endif

/* shared/ecc_calc_pkg.sv */
// Types shared by the parity calculator modules
package ecc_calc_pkg;

  typedef logic [7:0]  data_byte_t;
  typedef logic [31:0] bus_word_t;
  typedef logic [1:0]  htrans_t;
  typedef logic [2:0]  hsize_t;
  typedef logic [8:0]  byte_index_t;

  // Block size modes selected by block_size_select
  typedef enum logic {
    MODE_TWO_SMALL = 1'b0,
    MODE_ONE_LARGE = 1'b1
  } block_mode_t;

  localparam htrans_t HTRANS_NONSEQ = 2'h2;

endpackage : ecc_calc_pkg

/* logic/block_position_counter.sv */
// Counts data bytes folded since the last restart
`timescale 1ns/1ns
module block_position_counter #(
  parameter int INDEX_W = 9
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               clear,
  input  wire logic               fold,
  output logic [INDEX_W-1:0]      byte_index
);

  logic [INDEX_W-1:0] next_byte_index;

  // Next position: restart wins, otherwise step on each byte and wrap
  always_comb begin
    next_byte_index = byte_index;
    if (clear) begin
      next_byte_index = '0;
    end else if (fold) begin
      next_byte_index = byte_index + INDEX_W'(1);
    end
  end

  // Position register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byte_index <= '0;
    end else begin
      byte_index <= next_byte_index;
    end
  end

endmodule : block_position_counter

/* logic/parity_result_set.sv */
// Running row and column parity for one result set
`timescale 1ns/1ns
`include "ecc_calc_defs.svh"
module parity_result_set #(
  parameter int ADDR_W = 8
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   clear,
  input  wire logic                   fold,
  input  wire logic [ADDR_W-1:0]      byte_addr,
  input  wire logic [7:0]             data,
  output logic [2*ADDR_W-1:0]         row_parity,
  output logic [`COL_PARITY_W-1:0]    col_parity
);

  logic [2*ADDR_W-1:0]      next_row_parity;
  logic [2*ADDR_W-1:0]      row_term;
  logic [`COL_PARITY_W-1:0] next_col_parity;
  logic [`COL_PARITY_W-1:0] col_term;
  logic                     byte_parity;

  assign byte_parity = ^data;

  // Row terms: odd bit where address bit is one, even bit where zero
  genvar gi;
  generate
    for (gi = 0; gi < ADDR_W; gi++) begin : g_row
      assign row_term[2*gi+1] = byte_parity & byte_addr[gi];
      assign row_term[2*gi]   = byte_parity & ~byte_addr[gi];
    end
  endgenerate

  // Column terms over bit positions with bit j of position one or zero
  generate
    for (gi = 0; gi < 3; gi++) begin : g_col
      assign col_term[2*gi+1] = ^(data & (gi == 0 ? 8'haa : gi == 1 ? 8'hcc : 8'hf0));
      assign col_term[2*gi]   = ^(data & (gi == 0 ? 8'h55 : gi == 1 ? 8'h33 : 8'h0f));
    end
  endgenerate

  // Fold the byte in; restart clears and wins over a byte
  always_comb begin
    next_row_parity = row_parity;
    next_col_parity = col_parity;
    if (clear) begin
      next_row_parity = '0;
      next_col_parity = '0;
    end else if (fold) begin
      next_row_parity = row_parity ^ row_term;
      next_col_parity = col_parity ^ col_term;
    end
  end

  // Parity registers, zero after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row_parity <= '0;
      col_parity <= '0;
    end else begin
      row_parity <= next_row_parity;
      col_parity <= next_col_parity;
    end
  end

endmodule : parity_result_set

/* sim/ecc_calc_monitor.sv */
// Register bus checker for the page parity calculator
`timescale 1ns/1ns
module ecc_calc_monitor
  import ecc_calc_pkg::*;
(
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    hsel,
  input wire ecc_calc_pkg::bus_word_t haddr,
  input wire ecc_calc_pkg::htrans_t   htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire ecc_calc_pkg::bus_word_t hrdata,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire logic                    byte_ready,
  input wire logic                    byte_valid
);
  // ****************************************************************
  // Address phase decode and clean-state tracking
  // ****************************************************************
  wire logic [15:0] idx = haddr[17:2];
  wire logic        rd  = hsel & htrans[1] & hready & ~hwrite & (haddr[31:18] == '0) & (haddr[1:0] == 2'h0);
  wire logic        wr  = hsel & htrans[1] & hready & hwrite & (haddr[31:18] == '0) & (haddr[1:0] == 2'h0);
  wire logic        rd_any = hsel & htrans[1] & hready & ~hwrite;
  logic             wr_q;
  logic             clean;
  // Clean means no byte folded since reset or restart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      clean <= 1'b1;
    end else begin
      wr_q <= wr && idx == 16'he629;
      if (wr_q)
        clean <= 1'b1;
      else if (byte_valid)
        clean <= 1'b0;
    end
  end
  // ****************************************************************
  // Read data rules
  // ****************************************************************
  AST_CFG_ONE_BIT: assert property (
    @(posedge hclk) disable iff (!hresetn) rd && idx == 16'he628 |=> hrdata[31:1] == '0)
    else $error("config read shows more than bit 0");
  AST_RESTART_READS_ZERO: assert property (
    @(posedge hclk) disable iff (!hresetn) rd && idx == 16'he629 |=> hrdata == '0)
    else $error("restart register read not zero");
  AST_ROW_HIGH_BYTE: assert property (
    @(posedge hclk) disable iff (!hresetn) rd && (idx == 16'he62a || idx == 16'he62d) |=> hrdata[31:8] == '0)
    else $error("row high read wider than a byte");
  AST_ROW_LOW_BYTE: assert property (
    @(posedge hclk) disable iff (!hresetn) rd && (idx == 16'he62b || idx == 16'he62e) |=> hrdata[31:8] == '0)
    else $error("row low read wider than a byte");
  AST_FIRST_TOP_BYTE: assert property (
    @(posedge hclk) disable iff (!hresetn) rd && idx == 16'he62c |=> hrdata[31:8] == '0)
    else $error("first column byte wider than a byte");
  AST_SECOND_COL_LOW_ZERO: assert property (
    @(posedge hclk) disable iff (!hresetn) rd && idx == 16'he62f |=> hrdata[31:8] == '0 && hrdata[1:0] == 2'h0)
    else $error("second column byte low bits not zero");
  AST_CLEAN_RESULTS_ZERO: assert property (
    @(posedge hclk) disable iff (!hresetn) rd && clean && idx >= 16'he62a && idx <= 16'he62f |=> hrdata == '0)
    else $error("result not zero after reset or restart");
  AST_READ_DATA_HOLDS: assert property (
    @(posedge hclk) disable iff (!hresetn) !rd_any |=> $stable(hrdata))
    else $error("read data changed without a read");
  AST_BUS_ALWAYS_OKAY: assert property (
    @(posedge hclk) disable iff (!hresetn) hreadyout && !hresp && byte_ready)
    else $error("bus or stream answer not ready and okay");
endmodule : ecc_calc_monitor

bind flash_page_ecc_calculator ecc_calc_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .byte_ready(byte_ready), .byte_valid(byte_valid));

/* sim/testbench.sv */
// Self-checking bench for the page parity calculator
`timescale 1ns/1ns
module testbench;
  import ecc_calc_pkg::*;
  logic       hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, byte_valid = 0, dp = 0;
  bus_word_t  haddr = '0, hwdata = '0, hrdata;
  htrans_t    htrans = '0;
  data_byte_t byte_data = '0;
  wire logic  hready;
  logic       hresp, byte_ready;
  logic [7:0] exp_q[$];
  logic [31:0] lfsr = 32'hed9d7032;
  logic [17:0] r1;
  logic [15:0] r2;
  logic [5:0]  c1, c2;
  int          pos, err_count = 0, check_count = 0;
  // Clock at 50 MHz
  always #10 hclk = ~hclk;
  flash_page_ecc_calculator dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
  endfunction : nxt
  function automatic logic [7:0] res(input int k);
    logic [7:0] v[6];
    v = '{r1[15:8], r1[7:0], {c1, r1[17:16]}, r2[15:8], r2[7:0], {c2, 2'b00}};
    return v[k];
  endfunction : res
  task automatic chk(input bus_word_t s, input bus_word_t e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic wait_rdy();
    int t = 0;
    do begin
      @(posedge hclk);
      t++;
    end while (hready !== 1'b1 && t < 20);
    if (t >= 20) begin
      err_count++;
      end_sim();
    end
  endtask : wait_rdy
  // One single word transfer; a read notes its expected byte
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] wd, input logic [7:0] ex);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'b00};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    dp <= !w;
    if (!w) exp_q.push_back(ex);
    wait_rdy();
    dp <= 1'b0;
  endtask : xfer
  task automatic clr();
    r1 = '0;
    r2 = '0;
    c1 = '0;
    c2 = '0;
    pos = 0;
  endtask : clr
  // Streams random bytes back to back and folds them into the model
  task automatic feed(input int n, input logic m);
    logic [8:0] a;
    logic [5:0] c;
    data_byte_t d;
    for (int k = 0; k < n; k++) begin
      @(posedge hclk);
      lfsr = nxt(lfsr);
      d = lfsr[7:0];
      byte_valid <= 1'b1;
      byte_data <= d;
      a = pos[8:0];
      c = {^(d & 8'hf0), ^(d & 8'h0f), ^(d & 8'hcc), ^(d & 8'h33), ^(d & 8'haa), ^(d & 8'h55)};
      for (int i = 0; i < 9; i++)
        if (!m && a[8] && i < 8) r2[2*i+a[i]] ^= ^d;
        else if (m || (!a[8] && i < 8)) r1[2*i+a[i]] ^= ^d;
      if (!m && a[8]) c2 ^= c;
      else c1 ^= c;
      pos = (pos + 1) % 512;
    end
    @(posedge hclk);
    byte_valid <= 1'b0;
  endtask : feed
  task automatic rd_all();
    for (int k = 0; k < 6; k++) xfer(1'b0, 16'he62a + 16'(k), 8'h00, res(k));
  endtask : rd_all
  // Read data compared against the oldest note
  always @(posedge hclk) begin
    if (dp && hready === 1'b1) chk(hrdata, {24'h0, exp_q.pop_front()});
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    clr();
    for (int k = 0; k < 9; k++) xfer(1'b0, 16'he628 + 16'(k), 8'h00, 8'h00);
    xfer(1'b1, 16'he62c, 8'hff, 8'h00);
    xfer(1'b0, 16'he62c, 8'h00, 8'h00);
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, 16'he628, {7'h7f, m[0]}, 8'h00);
      xfer(1'b0, 16'he628, 8'h00, {7'h0, m[0]});
      xfer(1'b1, 16'he629, lfsr[7:0], 8'h00);
      clr();
      feed(300 + 220 * m, m[0]);
      rd_all();
      xfer(1'b1, 16'he629, lfsr[15:8], 8'h00);
      clr();
      rd_all();
    end
    // Reset in mid-run clears results and configuration
    feed(40, 1'b1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    clr();
    rd_all();
    xfer(1'b0, 16'he628, 8'h00, 8'h00);
    end_sim();
  end
endmodule : testbench
